// >>> core/cms_core.sv
// Measurement sequencing, register file and ready pin of the sensor
//
// The register offsets and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
module cms_core import cms_pkg::*; #(
  parameter int START_CYC = T_START_CYC,
  parameter int SAMPLE_CYC = T_SAMPLE_CYC,
  parameter int SEC_CYC = CYC_PER_S
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic enable_in,
  input wire logic sda_in,
  input wire logic [15:0] sample_value_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  output logic measurement_ready_low_out,
  output logic comm_ready_out,
  output logic irq_out
);
  // -----------------------------------------------
  // Power state: shutdown acts like reset
  // -----------------------------------------------
  logic pwr_rst;
  // R8 shutdown clears volatile
  assign pwr_rst = rst_in | ~enable_in;

  logic [15:0] nv_period;
  logic [10:0] nv_samples;
  logic [15:0] nv_cycles;
  logic [15:0] pend_period_q, pend_period_d;
  logic [10:0] pend_samples_q, pend_samples_d;
  logic commit;
  logic reboot_q, reboot_d;

  cms_nvmem u_nv (
    .ref_clk_in(ref_clk_in),
    .rst_in(pwr_rst | reboot_q),
    .commit_in(commit),
    .period_in(pend_period_q),
    .samples_in(pend_samples_q),
    .period_out(nv_period),
    .samples_out(nv_samples),
    .cycles_out(nv_cycles)
  );

  // -----------------------------------------------
  // Timers
  // -----------------------------------------------
  logic t_load, t_done, t_busy;
  logic [31:0] t_count;
  cms_timer #(.W(32)) u_tmr (
    .ref_clk_in(ref_clk_in),
    .rst_in(pwr_rst | reboot_q),
    .load_in(t_load),
    .count_in(t_count),
    .done_out(t_done),
    .busy_out(t_busy)
  );

  logic p_load, p_done, p_busy;
  logic [31:0] p_count;
  cms_timer #(.W(32)) u_per (
    .ref_clk_in(ref_clk_in),
    .rst_in(pwr_rst | reboot_q),
    .load_in(p_load),
    .count_in(p_count),
    .done_out(p_done),
    .busy_out(p_busy)
  );

  // -----------------------------------------------
  // Measurement sequencer
  // -----------------------------------------------
  cms_state_e st_q, st_d;
  logic single_q, single_d;
  logic [10:0] smp_cnt_q, smp_cnt_d;
  logic [26:0] acc_q, acc_d;
  logic [15:0] result_q, result_d;
  logic [31:0] state_data_q, state_data_d;
  logic meas_busy_q, meas_busy_d;
  logic ready_low_q, ready_low_d;
  logic comm_q, comm_d;
  logic [IRQ_W-1:0] irq_stat_q, irq_stat_d, irq_mask_q, irq_mask_d, ev;
  logic [31:0] rdata_q, rdata_d;
  logic irq_q, irq_d;
  logic start_cmd, sda_q;
  logic [10:0] eff_samples;
  logic bus_wr;

  // R1 no access before start
  assign bus_wr = wr_in & comm_q;
  assign start_cmd = bus_wr && addr_in == REG_CMD && wdata_in[CMD_START];
  assign commit = bus_wr && addr_in == REG_NV_COMMIT && wdata_in[0];
  // R16 clamp to one..max
  assign eff_samples = (nv_samples == 11'h000) ? 11'h001 :
                       (nv_samples > SAMPLES_MAX) ? SAMPLES_MAX : nv_samples;

  always_comb begin
    st_d = st_q;
    single_d = single_q;
    smp_cnt_d = smp_cnt_q;
    acc_d = acc_q;
    result_d = result_q;
    meas_busy_d = meas_busy_q;
    comm_d = comm_q;
    t_load = 1'b0;
    t_count = 32'h0;
    p_load = 1'b0;
    p_count = 32'(nv_period) * 32'(SEC_CYC);
    ev = '0;
    case (st_q)
      ST_BOOT: begin
        if (!t_busy && !t_done && !comm_q) begin
          t_load = 1'b1;
          t_count = 32'(START_CYC);
        end
        if (t_done) begin
          comm_d = 1'b1;
          // R3 default continuous
          // R14 first result valid
          if (!single_q) begin
            st_d = ST_SAMPLE;
            meas_busy_d = 1'b1;
            p_load = 1'b1;
            t_load = 1'b1;
            t_count = 32'(SAMPLE_CYC);
          end else begin
            st_d = ST_IDLE;
          end
        end
      end
      ST_IDLE: begin
        // R11 single on demand
        if (start_cmd) begin
          st_d = ST_SAMPLE;
          meas_busy_d = 1'b1;
          t_load = 1'b1;
          t_count = 32'(SAMPLE_CYC);
        end
      end
      ST_SAMPLE: begin
        // R2 per sample time
        if (t_done) begin
          acc_d = acc_q + 27'(sample_value_in);
          smp_cnt_d = smp_cnt_q + 11'h001;
          if (smp_cnt_q + 11'h001 >= eff_samples) begin
            result_d = 16'(acc_d / 27'(eff_samples));
            acc_d = '0;
            smp_cnt_d = '0;
            meas_busy_d = 1'b0;
            ev[IRQ_DONE] = 1'b1;
            st_d = single_q ? ST_SLEEP : ST_WAIT;
          end else begin
            t_load = 1'b1;
            t_count = 32'(SAMPLE_CYC);
          end
        end
      end
      ST_WAIT: begin
        if (p_done) begin
          st_d = ST_SAMPLE;
          meas_busy_d = 1'b1;
          p_load = 1'b1;
          t_load = 1'b1;
          t_count = 32'(SAMPLE_CYC);
        end
      end
      ST_SLEEP: begin
        // R12 wake on data pulse
        if (sda_in != sda_q) begin
          ev[IRQ_WAKE] = 1'b1;
          st_d = ST_IDLE;
        end else if (start_cmd) begin
          st_d = ST_SAMPLE;
          meas_busy_d = 1'b1;
          t_load = 1'b1;
          t_count = 32'(SAMPLE_CYC);
        end
      end
      default: st_d = ST_BOOT;
    endcase
    if (commit) begin
      ev[IRQ_NVWR] = 1'b1;
    end
    if (bus_wr && addr_in == REG_CTRL) begin
      single_d = wdata_in[CTRL_SINGLE];
    end
    // R17 ready follows result
    ready_low_d = ready_low_q;
    if (ev[IRQ_DONE]) begin
      ready_low_d = 1'b0;
    end else if (meas_busy_d) begin
      ready_low_d = 1'b1;
    end
  end

  // -----------------------------------------------
  // Register file
  // -----------------------------------------------
  always_comb begin
    pend_period_d = pend_period_q;
    pend_samples_d = pend_samples_q;
    state_data_d = state_data_q;
    irq_mask_d = irq_mask_q;
    reboot_d = 1'b0;
    rdata_d = 32'h0;
    // R4 applies after reboot
    if (bus_wr) begin
      if (addr_in == REG_PERIOD) begin
        pend_period_d = wdata_in[15:0];
      end else if (addr_in == REG_SAMPLES) begin
        pend_samples_d = wdata_in[10:0];
      end else if (addr_in == REG_CMD) begin
        reboot_d = wdata_in[CMD_REBOOT];
      end else if (addr_in == REG_STATE) begin
        state_data_d = wdata_in;
      end else if (addr_in == REG_IRQ_MASK) begin
        irq_mask_d = wdata_in[IRQ_W-1:0];
      end
    end
    // Set wins over write-one-to-clear
    irq_stat_d = irq_stat_q;
    if (bus_wr && addr_in == REG_IRQ_STAT) begin
      irq_stat_d = irq_stat_q & ~wdata_in[IRQ_W-1:0];
    end
    irq_stat_d = irq_stat_d | ev;
    irq_d = |(irq_stat_d & irq_mask_d);
    if (rd_in && comm_q) begin
      if (addr_in == REG_CTRL) begin
        rdata_d = {31'h0, single_q};
      end else if (addr_in == REG_PERIOD) begin
        rdata_d = {16'h0, nv_period};
      end else if (addr_in == REG_SAMPLES) begin
        rdata_d = {21'h0, nv_samples};
      end else if (addr_in == REG_STATUS) begin
        rdata_d = {26'h0, st_q, meas_busy_q, comm_q, p_busy};
      end else if (addr_in == REG_RESULT) begin
        rdata_d = {16'h0, result_q};
      end else if (addr_in == REG_STATE) begin
        rdata_d = state_data_q;
      end else if (addr_in == REG_IRQ_STAT) begin
        rdata_d = {29'h0, irq_stat_q};
      end else if (addr_in == REG_IRQ_MASK) begin
        rdata_d = {29'h0, irq_mask_q};
      end else if (addr_in == REG_NV_COUNT) begin
        rdata_d = {16'h0, nv_cycles};
      end else begin
        rdata_d = 32'h0;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    sda_q <= sda_in;
    if (pwr_rst || reboot_q) begin
      st_q <= ST_BOOT;
      single_q <= pwr_rst ? 1'b0 : single_q;
      smp_cnt_q <= '0;
      acc_q <= '0;
      result_q <= '0;
      meas_busy_q <= 1'b0;
      ready_low_q <= 1'b1;
      comm_q <= 1'b0;
      pend_period_q <= PERIOD_RST;
      pend_samples_q <= SAMPLES_RST;
      state_data_q <= pwr_rst ? 32'h0 : state_data_q;
      irq_stat_q <= '0;
      irq_mask_q <= '0;
      reboot_q <= 1'b0;
      rdata_q <= 32'h0;
      irq_q <= 1'b0;
    end else begin
      st_q <= st_d;
      single_q <= single_d;
      smp_cnt_q <= smp_cnt_d;
      acc_q <= acc_d;
      result_q <= result_d;
      meas_busy_q <= meas_busy_d;
      ready_low_q <= ready_low_d;
      comm_q <= comm_d;
      pend_period_q <= pend_period_d;
      pend_samples_q <= pend_samples_d;
      state_data_q <= state_data_d;
      irq_stat_q <= irq_stat_d;
      irq_mask_q <= irq_mask_d;
      reboot_q <= reboot_d;
      rdata_q <= rdata_d;
      irq_q <= irq_d;
    end
  end

  assign rdata_out = rdata_q;
  // R17 ready low when done
  assign measurement_ready_low_out = ready_low_q;
  assign comm_ready_out = comm_q;
  assign irq_out = irq_q;
endmodule : cms_core

// >>> core/cms_nvmem.sv
// Nonvolatile configuration store with registered read data
`timescale 1ns/1ps
module cms_nvmem import cms_pkg::*; (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic commit_in,
  input wire logic [15:0] period_in,
  input wire logic [10:0] samples_in,
  output logic [15:0] period_out,
  output logic [10:0] samples_out,
  output logic [15:0] cycles_out
);
  // Storage survives rst_in; loads defaults only once at first use
  logic [15:0] per_mem;
  logic [10:0] smp_mem;
  logic init_q = 1'b0;
  logic [15:0] cyc_q, cyc_d;
  logic [15:0] per_q;
  logic [10:0] smp_q;

  always_comb begin
    cyc_d = cyc_q;
    if (commit_in && cyc_q != 16'hFFFF) begin
      cyc_d = cyc_q + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!init_q) begin
      init_q <= 1'b1;
      per_mem <= PERIOD_RST;
      smp_mem <= SAMPLES_RST;
      cyc_q <= 16'h0000;
    end else begin
      // R6 one cycle per commit
      cyc_q <= cyc_d;
      if (commit_in) begin
        per_mem <= period_in;
        smp_mem <= samples_in;
      end
    end
  end

  // R7 visible after reset
  always_ff @(posedge ref_clk_in) begin
    if (rst_in || !init_q) begin
      per_q <= init_q ? per_mem : PERIOD_RST;
      smp_q <= init_q ? smp_mem : SAMPLES_RST;
    end
  end

  assign period_out = per_q;
  assign samples_out = smp_q;
  assign cycles_out = cyc_q;
endmodule : cms_nvmem

// >>> core/cms_pkg.sv
// Constants and types of the gas sensor measurement controller
//
// Contract
// R1 - No communication accepted until minimum start delay after processor start.
// R2 - Each sample takes between minimum and maximum sample time, nominal typical.
// R3 - Reset default: continuous mode, sixteen second period, eight samples.
// R4 - New period or sample count applies only after soft reboot.
// R5 - Host keeps nonvolatile write cycles below the lifetime maximum.
// R6 - One multi-register write sequence consumes exactly one nonvolatile cycle.
// R7 - Newly written nonvolatile values read back only after a reset.
// R8 - Shutdown pin low powers down and loses all volatile state.
// R9 - Host saves state data before shutdown, restores it after power-up.
// R10 - Host writes state data before the start-measurement command.
// R11 - Single mode measures once only on host demand.
// R12 - Idle low-power sensor wakes on any serial data line pulse.
// R13 - Host may ignore the ready output and use worst-case timing.
// R14 - No warm-up: first reported measurement is already valid.
// R15 - Host sets period longer than samples times typical sample time.
// R16 - Sample count from one to the maximum, averaged into each result.
// R17 - Active-low ready output high while measuring, low when result available.
// R18 - Without ready output host waits samples times maximum sample time.
package cms_pkg;

  // -----------------------------------------------
  // Timing
  // -----------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int T_START_MS = 35;
  localparam int T_SAMPLE_MIN_MS = 160;
  localparam int T_SAMPLE_TYP_MS = 180;
  localparam int T_SAMPLE_MAX_MS = 300;
  localparam int CYC_PER_MS = CLK_MHZ * 1000;
  localparam int T_START_CYC = T_START_MS * CYC_PER_MS;
  localparam int T_SAMPLE_CYC = T_SAMPLE_TYP_MS * CYC_PER_MS;
  localparam int CYC_PER_S = 1000 * CYC_PER_MS;

  // -----------------------------------------------
  // Configuration defaults and limits
  // -----------------------------------------------
  localparam logic [15:0] PERIOD_RST = 16'h0010;
  localparam logic [10:0] SAMPLES_RST = 11'h008;
  localparam logic [10:0] SAMPLES_MAX = 11'h400;
  localparam int NV_CYCLES_MAX = 10000;

  // -----------------------------------------------
  // Register offsets
  // -----------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_PERIOD = 8'h04;
  localparam logic [7:0] REG_SAMPLES = 8'h08;
  localparam logic [7:0] REG_NV_COMMIT = 8'h0C;
  localparam logic [7:0] REG_CMD = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam logic [7:0] REG_RESULT = 8'h18;
  localparam logic [7:0] REG_STATE = 8'h1C;
  localparam logic [7:0] REG_IRQ_STAT = 8'h20;
  localparam logic [7:0] REG_IRQ_MASK = 8'h24;
  localparam logic [7:0] REG_NV_COUNT = 8'h28;

  // Command and field bits
  localparam int CMD_START = 0;
  localparam int CMD_REBOOT = 1;
  localparam int CTRL_SINGLE = 0;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_NVWR = 1;
  localparam int IRQ_WAKE = 2;
  localparam int IRQ_W = 3;

  typedef enum logic [2:0] {
    ST_BOOT = 3'b000,
    ST_IDLE = 3'b001,
    ST_SAMPLE = 3'b010,
    ST_WAIT = 3'b011,
    ST_SLEEP = 3'b100
  } cms_state_e;

endpackage : cms_pkg

// >>> core/cms_timer.sv
// Down counter raising a pulse when a loaded count expires
`timescale 1ns/1ps
module cms_timer import cms_pkg::*; #(
  parameter int W = 32
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic load_in,
  input wire logic [W-1:0] count_in,
  output logic done_out,
  output logic busy_out
);
  logic [W-1:0] cnt_q, cnt_d;
  logic done_q, done_d;
  logic busy_q, busy_d;

  always_comb begin
    cnt_d = cnt_q;
    done_d = 1'b0;
    busy_d = busy_q;
    if (load_in) begin
      cnt_d = count_in;
      busy_d = 1'b1;
    end else if (busy_q) begin
      if (cnt_q <= {{(W-1){1'b0}}, 1'b1}) begin
        busy_d = 1'b0;
        done_d = 1'b1;
      end else begin
        cnt_d = cnt_q - {{(W-1){1'b0}}, 1'b1};
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      cnt_q <= '0;
      done_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      done_q <= done_d;
      busy_q <= busy_d;
    end
  end

  assign done_out = done_q;
  assign busy_out = busy_q;
endmodule : cms_timer

// >>> tb/cms_core_checker.sv
// Port-level assertions for the measurement controller
`timescale 1ns/1ps
module cms_core_checker import cms_pkg::*; #(
  parameter int START_CYC = 20
) (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic enable_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [31:0] rdata_out,
  input wire logic measurement_ready_low_out,
  input wire logic comm_ready_out,
  input wire logic irq_out
);
  logic [15:0] boot_cnt_q;
  logic [15:0] boot_cnt_d;
  logic reboot_w;

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  // -----------------------------------------------
  // Cycles since the last restart
  // -----------------------------------------------
  assign reboot_w = wr_in && comm_ready_out && addr_in == REG_CMD && wdata_in[CMD_REBOOT];

  always_comb begin
    boot_cnt_d = (boot_cnt_q == 16'hFFFF) ? boot_cnt_q : boot_cnt_q + 16'h1;
    if (rst_in || !enable_in || reboot_w) begin
      boot_cnt_d = 16'h0;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    boot_cnt_q <= boot_cnt_d;
  end

  // -----------------------------------------------
  // Assertions
  // -----------------------------------------------
  a_reset_values: assert property ($fell(rst_in) |-> measurement_ready_low_out &&
    !comm_ready_out && !irq_out && rdata_out == 32'h0) else $error("reset values wrong");
  a_start_delay: assert property ($rose(comm_ready_out) |->
    boot_cnt_q >= START_CYC && boot_cnt_q <= START_CYC + 4) else $error("start delay wrong");
  a_shutdown_clears: assert property (!enable_in |=> !comm_ready_out &&
    measurement_ready_low_out && !irq_out) else $error("shutdown kept state");
  a_mask_silences: assert property (wr_in && comm_ready_out &&
    addr_in == REG_IRQ_MASK && wdata_in[2:0] == 3'h0 |-> ##2 (!irq_out)[*3])
    else $error("masked interrupt still high");
  a_rdata_idle: assert property (!rd_in |=> rdata_out == 32'h0)
    else $error("read data without read");
  a_early_refused: assert property (rd_in && !comm_ready_out |=> rdata_out == 32'h0)
    else $error("access before start delay answered");
  a_result_after_boot: assert property ($fell(measurement_ready_low_out) |->
    $past(comm_ready_out)) else $error("result during boot");
  a_status_comm: assert property (rd_in && comm_ready_out && addr_in == REG_STATUS |=>
    rdata_out[1] == $past(comm_ready_out)) else $error("status ready bit wrong");
  a_unmapped_zero: assert property (rd_in && addr_in == 8'h30 |=> rdata_out == 32'h0)
    else $error("unmapped read not zero");
endmodule : cms_core_checker

bind cms_core cms_core_checker #(.START_CYC(START_CYC)) cms_core_checker_inst (
  .ref_clk_in(ref_clk_in),
  .rst_in(rst_in),
  .enable_in(enable_in),
  .addr_in(addr_in),
  .wdata_in(wdata_in),
  .wr_in(wr_in),
  .rd_in(rd_in),
  .rdata_out(rdata_out),
  .measurement_ready_low_out(measurement_ready_low_out),
  .comm_ready_out(comm_ready_out),
  .irq_out(irq_out)
);

// >>> tb/cms_core_test.sv
// Self-checking testbench of the measurement controller
`timescale 1ns/1ps
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin fails++; \
  $display("unexpected at %0t: got %0h expected %0h", $time, got, exp); end end
module cms_core_test import cms_pkg::*;;
  localparam int ST = 20;
  localparam int SM = 10;
  localparam logic [15:0] LEVEL = 16'h0123;
  logic ref_clk_in, rst_in, enable_in, sda_in, wr_in, rd_in, pulse_in;
  logic [15:0] sample_value_in;
  logic [7:0] addr_in;
  logic [31:0] wdata_in, rdata_out;
  logic measurement_ready_low_out, comm_ready_out, irq_out;
  int fails = 0;
  int total_checks = 0;

  cms_core #(.START_CYC(ST), .SAMPLE_CYC(SM), .SEC_CYC(50)) cms_core_inst (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .enable_in(enable_in), .sda_in(sda_in),
    .sample_value_in(sample_value_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .measurement_ready_low_out(measurement_ready_low_out),
    .comm_ready_out(comm_ready_out), .irq_out(irq_out));
  cms_far_model cms_far_model_inst (.level_in(LEVEL), .pulse_in(pulse_in),
    .sample_value_out(sample_value_in), .sda_out(sda_in));

  always #2.5 ref_clk_in = !ref_clk_in;

  // -----------------------------------------------
  // Bus and wait helpers
  // -----------------------------------------------
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge ref_clk_in);
    wr_in <= 1'b0;
  endtask : bus_wr

  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge ref_clk_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask : bus_rd

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    bus_rd(a, v);
    `CHK(v, exp)
  endtask : rd_chk

  task automatic wait_until(input logic want_comm, output int n);
    n = 0;
    while ((want_comm ? comm_ready_out !== 1'b1 : measurement_ready_low_out !== 1'b0)
        && n < 2000) begin
      @(posedge ref_clk_in);
      n++;
    end
    `CHK(n < 2000, 1'b1)
  endtask : wait_until

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop

  // -----------------------------------------------
  // Scenarios
  // -----------------------------------------------
  task automatic test_defaults();
    int n;
    logic [31:0] v;
    `CHK(measurement_ready_low_out, 1'b1)
    wait_until(1'b1, n);
    `CHK(n >= ST, 1'b1)
    wait_until(1'b0, n);
    `CHK(n >= 8 * SM - 2, 1'b1)
    rd_chk(REG_RESULT, {16'h0, LEVEL});
    rd_chk(REG_CTRL, 32'h0);
    rd_chk(REG_PERIOD, 32'h10);
    rd_chk(REG_SAMPLES, 32'h8);
    rd_chk(8'h30, 32'h0);
    bus_rd(REG_STATUS, v);
    `CHK(v[1], 1'b1)
    $display("test defaults done");
  endtask : test_defaults

  task automatic test_reconfig();
    int n;
    logic [31:0] c0;
    bus_rd(REG_NV_COUNT, c0);
    bus_wr(REG_PERIOD, 32'h3);
    bus_wr(REG_SAMPLES, 32'h2);
    bus_wr(REG_NV_COMMIT, 32'h1);
    rd_chk(REG_NV_COUNT, c0 + 32'h1);
    rd_chk(REG_PERIOD, 32'h10);
    bus_wr(REG_CMD, 32'h2);
    repeat (3) @(posedge ref_clk_in);
    wait_until(1'b1, n);
    wait_until(1'b0, n);
    `CHK(n >= 2 * SM - 2, 1'b1)
    rd_chk(REG_PERIOD, 32'h3);
    rd_chk(REG_SAMPLES, 32'h2);
    $display("test reconfig done");
  endtask : test_reconfig

  task automatic test_single();
    int n;
    bus_wr(REG_CTRL, 32'h1);
    bus_wr(REG_CMD, 32'h2);
    repeat (3) @(posedge ref_clk_in);
    wait_until(1'b1, n);
    bus_wr(REG_IRQ_STAT, 32'h7);
    bus_wr(REG_IRQ_MASK, 32'h1);
    bus_wr(REG_CMD, 32'h1);
    repeat (2) @(posedge ref_clk_in);
    `CHK(measurement_ready_low_out, 1'b1)
    wait_until(1'b0, n);
    repeat (3) @(posedge ref_clk_in);
    `CHK(irq_out, 1'b1)
    rd_chk(REG_IRQ_STAT, 32'h1);
    bus_wr(REG_IRQ_STAT, 32'h1);
    repeat (3) @(posedge ref_clk_in);
    `CHK(irq_out, 1'b0)
    repeat (200) @(posedge ref_clk_in);
    rd_chk(REG_IRQ_STAT, 32'h0);
    pulse_in <= 1'b1;
    @(posedge ref_clk_in);
    pulse_in <= 1'b0;
    repeat (4) @(posedge ref_clk_in);
    rd_chk(REG_IRQ_STAT, 32'h4);
    `CHK(irq_out, 1'b0)
    bus_wr(REG_IRQ_MASK, 32'h4);
    repeat (2) @(posedge ref_clk_in);
    `CHK(irq_out, 1'b1)
    bus_wr(REG_IRQ_MASK, 32'h0);
    repeat (3) @(posedge ref_clk_in);
    `CHK(irq_out, 1'b0)
    $display("test single done");
  endtask : test_single

  task automatic test_shutdown();
    int n;
    logic [31:0] keep;
    bus_wr(REG_STATE, 32'hA5C3);
    bus_rd(REG_STATE, keep);
    `CHK(keep, 32'hA5C3)
    enable_in <= 1'b0;
    repeat (2) @(posedge ref_clk_in);
    #1;
    `CHK(comm_ready_out, 1'b0)
    `CHK(measurement_ready_low_out, 1'b1)
    @(posedge ref_clk_in);
    enable_in <= 1'b1;
    bus_wr(REG_STATE, 32'h1);
    rd_chk(REG_STATE, 32'h0);
    wait_until(1'b1, n);
    rd_chk(REG_STATE, 32'h0);
    rd_chk(REG_CTRL, 32'h0);
    rd_chk(REG_PERIOD, 32'h3);
    bus_wr(REG_STATE, keep);
    bus_wr(REG_CMD, 32'h1);
    rd_chk(REG_STATE, 32'hA5C3);
    $display("test shutdown done");
  endtask : test_shutdown

  initial begin
    ref_clk_in = 1'b0;
    rst_in = 1'b1;
    enable_in = 1'b1;
    pulse_in = 1'b0;
    addr_in = 8'h00;
    wdata_in = 32'h0;
    wr_in = 1'b0;
    rd_in = 1'b0;
    repeat (4) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    test_defaults();
    test_reconfig();
    test_single();
    test_shutdown();
    report_and_stop();
  end

  initial begin
    repeat (20000) @(posedge ref_clk_in);
    fails++;
    report_and_stop();
  end
endmodule : cms_core_test

// >>> tb/cms_far_model.sv
// Far side: raw sample source and pulled-up serial data line
`timescale 1ns/1ps
module cms_far_model (
  input wire logic [15:0] level_in,
  input wire logic pulse_in,
  output logic [15:0] sample_value_out,
  output logic sda_out
);
  // Line rests high; a request pulls it low
  assign sda_out = !pulse_in;
  assign sample_value_out = level_in;
endmodule : cms_far_model
